// ---- i2cr_pkg.sv ----
package i2cr_pkg;
  // Register indices on the plain register port
  localparam logic [2:0] ADDR_CTRL1 = 3'h0;
  localparam logic [2:0] ADDR_CTRL2 = 3'h1;
  localparam logic [2:0] ADDR_BAUD  = 3'h2;
  localparam logic [2:0] ADDR_STAT  = 3'h3;
  localparam logic [2:0] ADDR_MASK  = 3'h4;
  localparam logic [2:0] ADDR_PINS  = 3'h5;

  // Fields of serial_control_one
  localparam int BIT_PORT_EN  = 5;
  localparam int BIT_CLK_REL  = 4;
  localparam int MODE_LSB     = 0;
  localparam int MODE_W       = 4;
  // Fields of serial_control_two
  localparam int BIT_GCALL_EN = 7;

  // Codes of mode_select
  localparam logic [3:0] MODE_SLV7     = 4'h6;
  localparam logic [3:0] MODE_SLV10    = 4'h7;
  localparam logic [3:0] MODE_MASTER   = 4'h8;
  localparam logic [3:0] MODE_FW_MST   = 4'hb;
  localparam logic [3:0] MODE_SLV7_SS  = 4'he;
  localparam logic [3:0] MODE_SLV10_SS = 4'hf;

  // Interrupt status / mask layout
  localparam int IRQ_W     = 3;
  localparam int IRQ_ADDR  = 0;
  localparam int IRQ_START = 1;
  localparam int IRQ_STOP  = 2;

  // Reset values
  localparam logic [7:0]       RST_CTRL1 = 8'h00;
  localparam logic [7:0]       RST_CTRL2 = 8'h00;
  localparam logic [7:0]       RST_BAUD  = 8'h00;
  localparam logic [IRQ_W-1:0] RST_IRQ   = 3'h0;

  // Index of the last address byte bit before the compare
  localparam logic [2:0] LAST_BIT = 3'h7;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_SHIFT = 2'b01,
    ST_CHECK = 2'b11
  } i2cr_rx_state_t;
endpackage : i2cr_pkg

// ---- i2cr_baud_div.sv ----
`timescale 1ns/10ps
module i2cr_baud_div (
  input  wire logic       i_clk_sys, // System clock
  input  wire logic       i_rst_n,   // Async reset, active low
  input  wire logic       i_en,      // Run the divider
  input  wire logic [7:0] i_reload,  // baud_reload value
  output logic            o_tick     // One pulse per reload+1 cycles
);
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;

  assign o_tick = i_en && (cnt_q == i_reload);

  always_comb begin
    if (!i_en || o_tick) begin
      cnt_d = 8'h00;
    end else begin
      cnt_d = cnt_q + 8'h01;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule : i2cr_baud_div

// ---- i2cr_top.sv ----
// Summary of operation
// - A set port enable bit hands both bus pins to the port, else GPIO.
// - A slave holds the bus clock low while clock release is zero.
// - Code 1111 is a 10-bit slave that also flags start and stop.
// - Any other unlisted mode code selects no bus behaviour at all.
// - A master makes a bus clock of sysclk / (4 * (reload + 1)).
// - Every slave mode flags an interrupt on an own address match.
`timescale 1ns/10ps
module i2cr_top (
  input  wire logic       i_clk_sys,     // System clock, 10 MHz
  input  wire logic       i_rst_n,       // Async reset, active low
  input  wire logic [2:0] i_addr,        // Register index
  input  wire logic [7:0] i_wdata,       // Write data
  input  wire logic       i_we,          // Write strobe
  input  wire logic       i_re,          // Read strobe
  output logic      [7:0] o_rdata,       // Read data, cycle after i_re
  output logic            o_irq,         // Interrupt level, active high
  input  wire logic       i_scl,         // Clock pin level
  output logic            o_scl,         // Clock pin drive value
  output logic            o_scl_oe,      // Clock pin drive enable
  input  wire logic       i_sda,         // Data pin level
  output logic            o_sda,         // Data pin drive value
  output logic            o_sda_oe,      // Data pin drive enable
  input  wire logic       i_gpio_scl_o,  // GPIO value for clock pin
  input  wire logic       i_gpio_scl_oe, // GPIO enable for clock pin
  input  wire logic       i_gpio_sda_o,  // GPIO value for data pin
  input  wire logic       i_gpio_sda_oe  // GPIO enable for data pin
);
  // Registers
  logic [7:0]                ctrl1_q, ctrl1_d;
  logic [7:0]                ctrl2_q, ctrl2_d;
  logic [7:0]                baud_q, baud_d;
  logic [i2cr_pkg::IRQ_W-1:0] stat_q, stat_d;
  logic [i2cr_pkg::IRQ_W-1:0] mask_q, mask_d;
  logic [7:0]                rdata_d;
  // Pin synchronisers and pin drive
  logic scl_s1_q, scl_s2_q, scl_s3_q;
  logic sda_s1_q, sda_s2_q, sda_s3_q;
  logic scl_o_d, scl_oe_d, sda_o_d, sda_oe_d;
  // Slave receive
  i2cr_pkg::i2cr_rx_state_t rx_q, rx_d;
  logic [2:0]               bit_q, bit_d;
  logic [7:0]               sh_q, sh_d;
  // Master clock
  logic phase_q, phase_d, gen_low_q, gen_low_d, tick;

  logic       port_en, clk_rel, gcall_en;
  logic [3:0] mode;
  logic       is_slave, is_ss, is_master, is_i2c, slave_on, master_on;
  logic       start_det, stop_det, scl_rise, addr_match;
  logic       wr_stat;
  logic       rx_busy;
  logic [i2cr_pkg::IRQ_W-1:0] events;

  assign port_en  = ctrl1_q[i2cr_pkg::BIT_PORT_EN];
  assign clk_rel  = ctrl1_q[i2cr_pkg::BIT_CLK_REL];
  assign mode     = ctrl1_q[i2cr_pkg::MODE_LSB +: i2cr_pkg::MODE_W];
  assign gcall_en = ctrl2_q[i2cr_pkg::BIT_GCALL_EN];

  assign is_ss     = (mode == i2cr_pkg::MODE_SLV7_SS) ||
                     (mode == i2cr_pkg::MODE_SLV10_SS);
  assign is_slave  = is_ss || (mode == i2cr_pkg::MODE_SLV7) ||
                     (mode == i2cr_pkg::MODE_SLV10);
  assign is_master = (mode == i2cr_pkg::MODE_MASTER);
  // Unlisted codes fall out here and leave the pins released
  assign is_i2c    = is_slave || is_master ||
                     (mode == i2cr_pkg::MODE_FW_MST);
  assign slave_on  = port_en && is_slave;
  assign master_on = port_en && is_master;

  // Only the second and third stages feed the edge logic
  assign scl_rise  = scl_s2_q && !scl_s3_q;
  assign start_det = scl_s2_q && scl_s3_q && sda_s3_q && !sda_s2_q;
  assign stop_det  = scl_s2_q && scl_s3_q && !sda_s3_q && sda_s2_q;

  // Same compare serves 10-bit mode: software loads the 11110xx0 header
  assign addr_match = slave_on && (rx_q == i2cr_pkg::ST_CHECK) &&
                      ((sh_q[7:1] == baud_q[7:1]) ||
                       (gcall_en && (sh_q == 8'h00)));

  i2cr_baud_div u_div (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (i_rst_n),
    .i_en      (master_on),
    .i_reload  (baud_q),
    .o_tick    (tick)
  );

  // Two ticks per half period: period is 4 * (reload + 1) cycles
  always_comb begin
    phase_d   = 1'b0;
    gen_low_d = 1'b0;
    if (master_on) begin
      phase_d   = phase_q ^ tick;
      gen_low_d = gen_low_q ^ (tick && phase_q);
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      phase_q   <= 1'b0;
      gen_low_q <= 1'b0;
    end else begin
      phase_q   <= phase_d;
      gen_low_q <= gen_low_d;
    end
  end

  always_comb begin
    rx_d  = rx_q;
    bit_d = bit_q;
    sh_d  = sh_q;
    if (!slave_on || stop_det) begin
      rx_d = i2cr_pkg::ST_IDLE;
    end else if (start_det) begin
      rx_d  = i2cr_pkg::ST_SHIFT;
      bit_d = 3'h0;
    end else begin
      case (rx_q)
        i2cr_pkg::ST_IDLE: begin
          rx_d = i2cr_pkg::ST_IDLE;
        end
        i2cr_pkg::ST_SHIFT: begin
          if (scl_rise) begin
            sh_d  = {sh_q[6:0], sda_s2_q};
            bit_d = bit_q + 3'h1;
            if (bit_q == i2cr_pkg::LAST_BIT) begin
              rx_d = i2cr_pkg::ST_CHECK;
            end
          end
        end
        i2cr_pkg::ST_CHECK: begin
          // Data bytes and later addresses are not this block's job
          rx_d = i2cr_pkg::ST_IDLE;
        end
        default: begin
          rx_d = i2cr_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rx_q  <= i2cr_pkg::ST_IDLE;
      bit_q <= 3'h0;
      sh_q  <= 8'h00;
    end else begin
      rx_q  <= rx_d;
      bit_q <= bit_d;
      sh_q  <= sh_d;
    end
  end

  // Pin drive; disabled port passes the GPIO latch straight through
  always_comb begin
    scl_o_d  = i_gpio_scl_o;
    scl_oe_d = i_gpio_scl_oe;
    sda_o_d  = i_gpio_sda_o;
    sda_oe_d = i_gpio_sda_oe;
    if (port_en) begin
      scl_o_d  = 1'b0;
      sda_o_d  = 1'b0;
      sda_oe_d = 1'b0;
      if (is_slave) begin
        scl_oe_d = !clk_rel;
      end else if (is_master) begin
        scl_oe_d = gen_low_q;
      end else begin
        scl_oe_d = 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_scl    <= 1'b0;
      o_scl_oe <= 1'b0;
      o_sda    <= 1'b0;
      o_sda_oe <= 1'b0;
      scl_s1_q <= 1'b1;
      scl_s2_q <= 1'b1;
      scl_s3_q <= 1'b1;
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
      sda_s3_q <= 1'b1;
    end else begin
      o_scl    <= scl_o_d;
      o_scl_oe <= scl_oe_d;
      o_sda    <= sda_o_d;
      o_sda_oe <= sda_oe_d;
      scl_s1_q <= i_scl;
      scl_s2_q <= scl_s1_q;
      scl_s3_q <= scl_s2_q;
      sda_s1_q <= i_sda;
      sda_s2_q <= sda_s1_q;
      sda_s3_q <= sda_s2_q;
    end
  end

  // Register file; a new event beats a clear in the same cycle
  assign wr_stat = i_we && (i_addr == i2cr_pkg::ADDR_STAT);
  assign rx_busy = (rx_q != i2cr_pkg::ST_IDLE);
  always_comb begin
    events = '0;
    events[i2cr_pkg::IRQ_ADDR]  = addr_match;
    events[i2cr_pkg::IRQ_START] = slave_on && is_ss && start_det;
    events[i2cr_pkg::IRQ_STOP]  = slave_on && is_ss && stop_det;
    ctrl1_d = ctrl1_q;
    ctrl2_d = ctrl2_q;
    baud_d  = baud_q;
    mask_d  = mask_q;
    stat_d  = stat_q;
    if (wr_stat) begin
      stat_d = stat_q & ~i_wdata[i2cr_pkg::IRQ_W-1:0];
    end
    stat_d = stat_d | events;
    if (i_we) begin
      case (i_addr)
        i2cr_pkg::ADDR_CTRL1: ctrl1_d = i_wdata;
        i2cr_pkg::ADDR_CTRL2: ctrl2_d = i_wdata;
        i2cr_pkg::ADDR_BAUD:  baud_d  = i_wdata;
        i2cr_pkg::ADDR_MASK:  mask_d  = i_wdata[i2cr_pkg::IRQ_W-1:0];
        default: begin
        end
      endcase
    end
    rdata_d = 8'h00;
    if (i_re) begin
      case (i_addr)
        i2cr_pkg::ADDR_CTRL1: rdata_d = ctrl1_q;
        i2cr_pkg::ADDR_CTRL2: rdata_d = ctrl2_q;
        i2cr_pkg::ADDR_BAUD:  rdata_d = baud_q;
        i2cr_pkg::ADDR_STAT:  rdata_d = {5'h00, stat_q};
        i2cr_pkg::ADDR_MASK:  rdata_d = {5'h00, mask_q};
        i2cr_pkg::ADDR_PINS:  rdata_d = {4'h0, is_i2c, rx_busy,
                                         sda_s2_q, scl_s2_q};
        default:              rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl1_q <= i2cr_pkg::RST_CTRL1;
      ctrl2_q <= i2cr_pkg::RST_CTRL2;
      baud_q  <= i2cr_pkg::RST_BAUD;
      stat_q  <= i2cr_pkg::RST_IRQ;
      mask_q  <= i2cr_pkg::RST_IRQ;
      o_rdata <= 8'h00;
    end else begin
      ctrl1_q <= ctrl1_d;
      ctrl2_q <= ctrl2_d;
      baud_q  <= baud_d;
      stat_q  <= stat_d;
      mask_q  <= mask_d;
      o_rdata <= rdata_d;
    end
  end

  assign o_irq = |(stat_q & mask_q);

  // Helper: cycles between master clock edges
  logic [9:0] hc_q;
  logic       hc_ok_q;
  logic       gen_toggle;
  assign gen_toggle = gen_low_d != gen_low_q;
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hc_q    <= 10'h000;
      hc_ok_q <= 1'b1;
    end else begin
      hc_q    <= (!master_on || gen_toggle) ? 10'h000 : hc_q + 10'h001;
      hc_ok_q <= (i_we && (i_addr == i2cr_pkg::ADDR_BAUD)) ? 1'b0 :
                 (gen_toggle ? 1'b1 : hc_ok_q);
    end
  end

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);

  AST_PORT_OFF_GPIO: assert property (
    !port_en |=> (o_scl_oe == $past(i_gpio_scl_oe)) &&
                 (o_sda_oe == $past(i_gpio_sda_oe)) &&
                 (o_scl == $past(i_gpio_scl_o)))
    else $error("disabled port does not pass gpio");
  AST_PORT_ON_OPEN_DRAIN: assert property (
    port_en |=> !o_scl && !o_sda && !o_sda_oe)
    else $error("enabled port drives pins high");
  AST_SLAVE_STRETCH: assert property (
    slave_on && !clk_rel |=> o_scl_oe)
    else $error("slave does not hold clock low");
  AST_SLAVE_RELEASE: assert property (
    slave_on && clk_rel |=> !o_scl_oe)
    else $error("slave holds clock while released");
  AST_RESERVED_IDLE: assert property (
    port_en && !is_i2c |=> !o_scl_oe && !o_sda_oe)
    else $error("unlisted mode drives the bus");
  AST_SS_START_FLAG: assert property (
    slave_on && is_ss && start_det |=> stat_q[i2cr_pkg::IRQ_START])
    else $error("start not flagged in start/stop mode");
  AST_PLAIN_NO_STOP: assert property (
    port_en && !is_ss && !stat_q[i2cr_pkg::IRQ_STOP]
      |=> !stat_q[i2cr_pkg::IRQ_STOP])
    else $error("stop flagged in plain slave mode");
  AST_MASTER_HALF: assert property (
    master_on && gen_toggle && hc_ok_q && $stable(baud_q)
      |-> hc_q == {1'b0, baud_q, 1'b1})
    else $error("master clock half period wrong");
  AST_ADDR_FLAG: assert property (
    addr_match |=> stat_q[i2cr_pkg::IRQ_ADDR] ##0 o_irq == mask_q[0] ||
                   !mask_q[0])
    else $error("address match not flagged");
  AST_READ_ONE_CYCLE: assert property (
    !i_re |=> o_rdata == 8'h00)
    else $error("read data outside read cycle");

  COV_MASTER_TOGGLE: cover property (master_on && gen_toggle ##[1:600]
                                     gen_toggle);
  COV_ADDR_MATCH:    cover property (addr_match);
  COV_SS_STOP:       cover property (slave_on && is_ss && stop_det);
  COV_STRETCH:       cover property (slave_on && !clk_rel ##1 o_scl_oe);
endmodule : i2cr_top

// ---- i2cr_bus_model.sv ----
`timescale 1ns/10ps
module i2cr_bus_model (
  input  wire logic i_clk_sys, // System clock
  input  wire logic i_scl,     // Clock wire level
  output logic      o_scl_low, // Pull clock wire low
  output logic      o_sda_low  // Pull data wire low
);
  initial begin
    o_scl_low = 1'b0;
    o_sda_low = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge i_clk_sys);
  endtask : tick

  // Start, byte MSB first, ack slot, stop; honours clock stretching
  task automatic send_frame(input logic [7:0] b, input int half);
    int         w;
    logic [8:0] s;
    s = {b, 1'b1};
    tick(1);
    o_sda_low <= 1'b1;
    tick(half);
    o_scl_low <= 1'b1;
    repeat (9) begin
      tick(half);
      o_sda_low <= ~s[8];
      s = s << 1;
      tick(half);
      o_scl_low <= 1'b0;
      w = 0;
      while (i_scl !== 1'b1 && w < 500) begin
        tick(1);
        w++;
      end
      tick(half);
      o_scl_low <= 1'b1;
    end
    tick(half);
    o_sda_low <= 1'b1;
    tick(half);
    o_scl_low <= 1'b0;
    tick(half);
    o_sda_low <= 1'b0;
    tick(half);
  endtask : send_frame
endmodule : i2cr_bus_model

// ---- test_i2c_port_control_regs.sv ----
`timescale 1ns/10ps
module test_i2c_port_control_regs;
  logic       clk, rst_n, we, re, irq, scl_w, sda_w;
  logic       scl_o, scl_oe, sda_o, sda_oe, m_scl, m_sda;
  logic [2:0] addr;
  logic [7:0] wdata, rdata;
  logic [3:0] gpio;
  int         failures, check_count, cyc;

  always #50 clk = ~clk;
  // Pull-ups on both wires
  assign scl_w = ~(m_scl | (scl_oe & ~scl_o));
  assign sda_w = ~(m_sda | (sda_oe & ~sda_o));

  i2cr_top i_dut (.i_clk_sys(clk), .i_rst_n(rst_n), .i_addr(addr),
    .i_wdata(wdata), .i_we(we), .i_re(re), .o_rdata(rdata), .o_irq(irq),
    .i_scl(scl_w), .o_scl(scl_o), .o_scl_oe(scl_oe), .i_sda(sda_w),
    .o_sda(sda_o), .o_sda_oe(sda_oe), .i_gpio_scl_o(gpio[3]),
    .i_gpio_scl_oe(gpio[2]), .i_gpio_sda_o(gpio[1]),
    .i_gpio_sda_oe(gpio[0]));
  i2cr_bus_model i_bus (.i_clk_sys(clk), .i_scl(scl_w), .o_scl_low(m_scl),
    .o_sda_low(m_sda));

  task test_done;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : test_done

  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      failures++;
      test_done;
    end
  end

  task chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask : wr

  task rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    #1 v = rdata;
  endtask : rd

  task settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle

  function automatic logic listed(input logic [3:0] m);
    return m inside {i2cr_pkg::MODE_SLV7, i2cr_pkg::MODE_SLV10,
      i2cr_pkg::MODE_MASTER, i2cr_pkg::MODE_FW_MST,
      i2cr_pkg::MODE_SLV7_SS, i2cr_pkg::MODE_SLV10_SS};
  endfunction : listed

  // Status: start and stop flagged only by the two upper slave codes
  function automatic logic [7:0] exp_stat(input logic [3:0] m,
                                          input logic hit);
    logic ss;
    ss = (m == i2cr_pkg::MODE_SLV7_SS) || (m == i2cr_pkg::MODE_SLV10_SS);
    return {5'h0, ss, ss, hit};
  endfunction : exp_stat

  // Cycles between two clock drive changes of the master
  task automatic half_period(input logic [7:0] r, input logic rel);
    int   n;
    logic last;
    wr(i2cr_pkg::ADDR_BAUD, r);
    wr(i2cr_pkg::ADDR_CTRL1, {3'h1, rel, i2cr_pkg::MODE_MASTER});
    for (int k = 0; k < 2; k++) begin
      settle(1);
      last = scl_oe;
      n = 1;
      while (scl_oe === last && n < 2000) begin
        settle(1);
        n++;
      end
    end
    chk(8'(n), 8'((r + 8'h01) * 2));
  endtask : half_period

  initial begin
    logic [7:0] v, own, e;
    logic [3:0] m;
    logic [3:0] slv [4];
    clk = 0;
    rst_n = 0;
    we = 0;
    re = 0;
    addr = 0;
    wdata = 0;
    gpio = 0;
    failures = 0;
    check_count = 0;
    cyc = 0;
    slv = '{4'h6, 4'h7, 4'he, 4'hf};
    void'($urandom(95));
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    for (int a = 0; a < 8; a++) begin
      rd(3'(a), v);
      chk(v, (a == 5) ? 8'h03 : 8'h00);
    end
    repeat (8) begin
      v = $urandom;
      wr(i2cr_pkg::ADDR_CTRL2, v);
      rd(i2cr_pkg::ADDR_CTRL2, e);
      chk(e, v);
      wr(i2cr_pkg::ADDR_MASK, v);
      rd(i2cr_pkg::ADDR_MASK, e);
      chk(e, {5'h0, v[2:0]});
      wr(3'h6, v);
      rd(3'h6, e);
      chk(e, 8'h00);
    end
    wr(i2cr_pkg::ADDR_CTRL2, 8'h00);
    repeat (4) begin
      @(posedge clk) gpio <= 4'($urandom);
      settle(2);
      chk({4'h0, scl_o, scl_oe, sda_o, sda_oe}, {4'h0, gpio});
    end
    @(posedge clk) gpio <= 4'hf;
    for (int k = 0; k < 16; k++) begin
      m = 4'(k);
      wr(i2cr_pkg::ADDR_CTRL1, {4'h3, m});
      settle(2);
      rd(i2cr_pkg::ADDR_PINS, v);
      chk(v & 8'h08, {4'h0, listed(m), 3'h0});
      chk({7'h0, sda_oe}, 8'h00);
      if (!listed(m))
        chk({6'h0, scl_oe, sda_oe}, 8'h00);
    end
    wr(i2cr_pkg::ADDR_CTRL1, 8'h00);
    @(posedge clk) gpio <= 4'h0;
    wr(i2cr_pkg::ADDR_CTRL1, 8'h26);
    settle(2);
    chk({6'h0, scl_oe, scl_o}, 8'h02);
    wr(i2cr_pkg::ADDR_CTRL1, 8'h36);
    settle(2);
    chk({6'h0, scl_oe, scl_o}, 8'h00);
    half_period(8'h00, 1'b0);
    half_period(8'($urandom_range(31)), 1'b1);
    wr(i2cr_pkg::ADDR_CTRL1, 8'h00);
    for (int k = 0; k < 8; k++) begin
      m = slv[k / 2];
      own = {7'($urandom_range(1, 127)), 1'b0};
      wr(i2cr_pkg::ADDR_BAUD, own);
      wr(i2cr_pkg::ADDR_MASK, 8'h07);
      wr(i2cr_pkg::ADDR_STAT, 8'h07);
      wr(i2cr_pkg::ADDR_CTRL1, {4'h3, m});
      i_bus.send_frame(own ^ ((k % 2) ? 8'h80 : 8'h01), (k % 2) ? 4 : 25);
      settle(4);
      e = exp_stat(m, k % 2 == 0);
      rd(i2cr_pkg::ADDR_STAT, v);
      chk(v, e);
      chk({7'h0, irq}, {7'h0, |e});
      wr(i2cr_pkg::ADDR_MASK, 8'h00);
      settle(2);
      chk({7'h0, irq}, 8'h00);
      wr(i2cr_pkg::ADDR_STAT, 8'h07);
      rd(i2cr_pkg::ADDR_STAT, v);
      chk(v, 8'h00);
    end
    // General call byte matches only with general_call_enable set
    wr(i2cr_pkg::ADDR_CTRL2, 8'h80);
    i_bus.send_frame(8'h00, 4);
    settle(4);
    rd(i2cr_pkg::ADDR_STAT, v);
    chk(v, 8'h07);
    test_done;
  end
endmodule : test_i2c_port_control_regs
